// ===== rtl/cmpc_pkg.sv
package cmpc_pkg;
  localparam logic [11:0] CMPC_CS_OFFSET = 12'h000;
  localparam logic [31:0] CMPC_CS_RESET = 32'h0000_0000;
  // bits that software may change; 30 is status, the rest reserved
  localparam logic [31:0] CMPC_CS_WMASK = 32'h80DF_FFFD;
  localparam int CMPC_LOCK_BIT = 31;
  localparam int CMPC_MIRROR_BIT = 30;
  localparam int CMPC_SCALER_BIT = 23;
  localparam int CMPC_BRIDGE_BIT = 22;
  localparam int CMPC_BLANK_LSB = 18;
  localparam int CMPC_HYST_LSB = 16;
  localparam int CMPC_INVERT_BIT = 15;
  localparam int CMPC_ROUTE_LSB = 13;
  localparam int CMPC_PLUS_LSB = 10;
  localparam int CMPC_MINT_LSB = 7;
  localparam int CMPC_MEXT_LSB = 4;
  localparam int CMPC_MODE_LSB = 2;
  localparam int CMPC_ON_BIT = 0;

  localparam logic [2:0] CMPC_BLANK_NONE = 3'h0;
  localparam logic [2:0] CMPC_BLANK_TMR0 = 3'h1;
  localparam logic [2:0] CMPC_BLANK_TMR7 = 3'h2;
  localparam logic [2:0] CMPC_BLANK_TMR1 = 3'h3;
  localparam logic [1:0] CMPC_ROUTE_TMR0 = 2'h1;
  localparam logic [1:0] CMPC_ROUTE_TMR7 = 2'h2;
  localparam logic [2:0] CMPC_MINT_DAC = 3'h4;
  localparam logic [2:0] CMPC_MINT_EXT = 3'h5;
  localparam logic [2:0] CMPC_MINT_FULL = 3'h3;

  typedef enum logic [1:0] {
    CMPC_HYST_NONE,
    CMPC_HYST_LOW,
    CMPC_HYST_MED,
    CMPC_HYST_HIGH
  } cmpc_hyst_t;

  // settings toward the analog comparator
  typedef struct packed {
    logic comparator_on;
    logic [1:0] speed_power_mode;
    cmpc_hyst_t hysteresis_level;
    logic [2:0] plus_input_sel;
    logic [3:0] minus_ref_onehot;
    logic minus_converter;
    logic minus_pin_used;
    logic [2:0] minus_external_sel;
    logic scaler_enable;
    logic bridge_enable;
  } cmpc_analog_t;

  // timer channel-1 blanking windows
  typedef struct packed {
    logic tmr0;
    logic tmr7;
    logic tmr1;
  } cmpc_blank_t;
endpackage

// ===== rtl/cmpc_ctrl_status.sv
`timescale 1ns/1ps
module cmpc_ctrl_status
  import cmpc_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comp_raw,
  input wire cmpc_blank_t blank_in,
  output cmpc_analog_t analog_cfg,
  output logic comp_out_port,
  output logic comp_to_tmr0_ch0,
  output logic comp_to_tmr7_ch0
);

  logic [31:0] cs_r;
  logic [31:0] cs_nxt;
  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic mirror_r;
  logic mirror_nxt;
  logic addr_hit;
  logic wr_acc;
  logic [2:0] blank_sel;
  logic [1:0] route_sel;
  logic [2:0] mint_sel;
  logic blank_now;
  logic blanked;
  logic final_out;

  assign addr_hit = (paddr == ADDR_W'(CMPC_CS_OFFSET));
  assign wr_acc = psel && penable && pwrite && addr_hit;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;

  always_comb
  begin
    cs_nxt = cs_r;
    if (wr_acc && !cs_r[CMPC_LOCK_BIT])
    begin
      cs_nxt = pwdata & CMPC_CS_WMASK;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      cs_r <= CMPC_CS_RESET;
    end
    else
    begin
      cs_r <= cs_nxt;
    end
  end

  // third stage filters a metastable settle of the second
  always_comb
  begin
    sync_nxt = {sync_r[1:0], comp_raw};
    mirror_nxt = mirror_r;
    if (sync_r[1] == sync_r[2])
    begin
      mirror_nxt = sync_r[2];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      sync_r <= 3'h0;
      mirror_r <= 1'b0;
    end
    else
    begin
      sync_r <= sync_nxt;
      mirror_r <= mirror_nxt;
    end
  end

  always_comb
  begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite && addr_hit)
    begin
      prdata = cs_r;
      prdata[CMPC_MIRROR_BIT] = mirror_r;
    end
  end

  assign blank_sel = cs_r[CMPC_BLANK_LSB +: 3];
  assign route_sel = cs_r[CMPC_ROUTE_LSB +: 2];
  assign mint_sel = cs_r[CMPC_MINT_LSB +: 3];

  // reserved blanking codes behave as no blanking
  always_comb
  begin
    case (blank_sel)
      CMPC_BLANK_TMR0: blank_now = blank_in.tmr0;
      CMPC_BLANK_TMR7: blank_now = blank_in.tmr7;
      CMPC_BLANK_TMR1: blank_now = blank_in.tmr1;
      default: blank_now = 1'b0;
    endcase
  end

  // pure gates from pin to pin: keeps working with the clock stopped
  assign blanked = comp_raw & ~blank_now;
  assign final_out = blanked ^ cs_r[CMPC_INVERT_BIT];
  assign comp_out_port = final_out;
  assign comp_to_tmr0_ch0 = final_out
    && (route_sel == CMPC_ROUTE_TMR0);
  assign comp_to_tmr7_ch0 = final_out
    && (route_sel == CMPC_ROUTE_TMR7);

  always_comb
  begin
    analog_cfg.comparator_on = cs_r[CMPC_ON_BIT];
    analog_cfg.speed_power_mode = cs_r[CMPC_MODE_LSB +: 2];
    analog_cfg.hysteresis_level =
      cmpc_hyst_t'(cs_r[CMPC_HYST_LSB +: 2]);
    analog_cfg.plus_input_sel = cs_r[CMPC_PLUS_LSB +: 3];
    analog_cfg.minus_ref_onehot = 4'h0;
    if (mint_sel <= CMPC_MINT_FULL)
    begin
      analog_cfg.minus_ref_onehot[mint_sel[1:0]] = 1'b1;
    end
    analog_cfg.minus_converter = (mint_sel == CMPC_MINT_DAC);
    analog_cfg.minus_pin_used = (mint_sel == CMPC_MINT_EXT);
    analog_cfg.minus_external_sel = cs_r[CMPC_MEXT_LSB +: 3];
    analog_cfg.scaler_enable = cs_r[CMPC_SCALER_BIT];
    analog_cfg.bridge_enable = cs_r[CMPC_BRIDGE_BIT];
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  reset_clear_a: assert property (
    $past(srst) |-> (cs_r == CMPC_CS_RESET) && !mirror_r)
    else $error("register not cleared by reset");

  lock_freeze_a: assert property (
    cs_r[CMPC_LOCK_BIT] |=> $stable(cs_r))
    else $error("locked register changed");

  unlocked_write_a: assert property (
    (wr_acc && !cs_r[CMPC_LOCK_BIT])
      |=> cs_r == ($past(pwdata) & CMPC_CS_WMASK))
    else $error("write not stored");

  mirror_follow_a: assert property (
    comp_raw [*4] |=> prdata[CMPC_MIRROR_BIT] || !(psel && addr_hit)
      || pwrite)
    else $error("mirror did not follow result");

  // a one-cycle dip must not reach the mirror; only agreed samples move it
  mirror_late_a: assert property (
    $changed(mirror_r) |-> mirror_r == $past(comp_raw, 3)
      && mirror_r == $past(comp_raw, 4))
    else $error("mirror not synchronised");

  blank_gate_a: assert property (
    (blank_sel == CMPC_BLANK_TMR0 && blank_in.tmr0)
      |-> comp_out_port == cs_r[CMPC_INVERT_BIT])
    else $error("blanking not applied");

  invert_out_a: assert property (
    (blank_sel == CMPC_BLANK_NONE)
      |-> comp_out_port == (comp_raw ^ cs_r[CMPC_INVERT_BIT]))
    else $error("polarity wrong");

  route_gate_a: assert property (
    (route_sel != CMPC_ROUTE_TMR0) |-> !comp_to_tmr0_ch0)
    else $error("timer 0 fed while not routed");

  route_follow_a: assert property (
    (route_sel == CMPC_ROUTE_TMR0) |-> comp_to_tmr0_ch0 == comp_out_port)
    else $error("timer 0 not fed while routed");

  route_tmr7_a: assert property (
    (route_sel != CMPC_ROUTE_TMR7) |-> !comp_to_tmr7_ch0)
    else $error("timer 7 fed while not routed");

  blank_reserved_a: assert property (
    (blank_sel > CMPC_BLANK_TMR1)
      |-> comp_out_port == (comp_raw ^ cs_r[CMPC_INVERT_BIT]))
    else $error("reserved blanking code gated output");

  minus_pin_a: assert property (
    analog_cfg.minus_pin_used |-> analog_cfg.minus_ref_onehot == 4'h0
      && !analog_cfg.minus_converter)
    else $error("minus input sources clash");

  scaler_bits_a: assert property (
    wr_acc && !cs_r[CMPC_LOCK_BIT]
      |=> analog_cfg.scaler_enable == $past(pwdata[CMPC_SCALER_BIT])
        && analog_cfg.bridge_enable == $past(pwdata[CMPC_BRIDGE_BIT]))
    else $error("scaler enables not taken");

endmodule // cmpc_ctrl_status

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb;
  import cmpc_pkg::*;
  logic clk_sys, srst, psel, penable, pwrite, comp_raw, se, bl, o;
  logic pready, pslverr, cport, ct0, ct7;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, em;
  logic [15:0] lf;
  logic [3:0] oh;
  logic [2:0] mi;
  cmpc_blank_t blank_in;
  cmpc_analog_t acfg;
  int error_cnt, checks, cyc;
  cmpc_ctrl_status cmpc_ctrl_status_inst (.clk_sys(clk_sys), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comp_raw(comp_raw), .blank_in(blank_in), .analog_cfg(acfg),
    .comp_out_port(cport), .comp_to_tmr0_ch0(ct0), .comp_to_tmr7_ch0(ct7));
  initial
  begin
    clk_sys = 0;
    forever #2 clk_sys = ~clk_sys;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // setup then access; answer taken at the edge that sees pready high
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
    begin
      @(posedge clk_sys);
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      error_cnt++;
      $display("[ERR] %0t timeout", $time);
      print_verdict;
    end
  end
  initial
  begin
    {srst, psel, penable, pwrite, comp_raw} = 5'h10;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    blank_in = '0;
    lf = 16'hD67F;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    apb(0, 12'h000, 0);
    chk(rd, 32'h0000_0000);
    chk({pready, se}, 2'h2);
    $display("reset test done");
    repeat (80)
    begin
      lf = lfsr(lf);
      em[31:16] = lf;
      lf = lfsr(lf);
      em[15:0] = lf;
      em[31] = 1'b0;
      em = em & CMPC_CS_WMASK;
      apb(1, 12'h000, em);
      apb(0, 12'h000, 0);
      chk(rd & 32'hBFFF_FFFF, em);
      mi = em[9:7];
      oh = (mi < 3'h4) ? (4'h1 << mi) : 4'h0;
      chk({13'h0, acfg}, {13'h0, em[0], em[3:2], em[17:16], em[12:10], oh,
        mi == 3'h4, mi == 3'h5, em[6:4], em[23], em[22]});
      @(posedge clk_sys);
      comp_raw <= lf[0];
      blank_in <= lf[3:1];
      #1 bl = em[20:18] == 3'h1 ? blank_in.tmr0 : em[20:18] == 3'h2 ?
        blank_in.tmr7 : em[20:18] == 3'h3 ? blank_in.tmr1 : 1'b0;
      o = (comp_raw & ~bl) ^ em[15];
      chk({cport, ct0, ct7}, {o, em[14:13] == 2'h1 && o,
        em[14:13] == 2'h2 && o});
    end
    $display("field test done");
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk_sys);
      comp_raw <= i[0];
      repeat (5) @(posedge clk_sys);
      apb(0, 12'h000, 0);
      chk(rd[30], i[0]);
    end
    $display("mirror test done");
    apb(1, 12'h004, 32'hFFFF_FFFF);
    chk(se, 1'b1);
    apb(0, 12'h000, 0);
    chk(rd & 32'hBFFF_FFFF, em);
    $display("unmapped test done");
    apb(1, 12'h000, 32'h8000_0001);
    apb(1, 12'h000, 32'h0000_00FC);
    apb(0, 12'h000, 0);
    chk(rd & 32'hBFFF_FFFF, 32'h8000_0001);
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    apb(0, 12'h000, 0);
    chk(rd & 32'hBFFF_FFFF, 32'h0000_0000);
    $display("lock test done");
    apb(1, 12'h000, 32'h0000_0001);
    apb(1, 12'h000, 32'h0000_2001);
    @(posedge clk_sys);
    comp_raw <= 1'b1;
    blank_in <= '0;
    #1 chk({ct0, ct7, cport}, 3'h5);
    @(posedge clk_sys);
    comp_raw <= 1'b0;
    #1 chk({ct0, ct7, cport}, 3'h0);
    $display("capture test done");
    print_verdict;
  end
endmodule // tb
